// ---- shared/pcc_pkg.sv ----
// Purpose: Constants and types for the loop and pump control register slice
// Assumes: Byte-wide registers reached by an upstream serial port decoder
// Notes:   Addresses are the 10-bit register addresses of the serial port
package pcc_pkg;

  localparam int          ADDR_W            = 10;
  localparam logic [9:0]  ADDR_TAG_LOW      = 10'h005;
  localparam logic [9:0]  ADDR_TAG_HIGH     = 10'h006;
  localparam logic [9:0]  ADDR_LOOP_PUMP    = 10'h010;

  localparam logic [7:0]  RST_TAG_LOW       = 8'h00;
  localparam logic [7:0]  RST_TAG_HIGH      = 8'h00;
  // Positive polarity, 4.8 mA, normal pump, asynchronous power-down
  localparam logic [7:0]  RST_LOOP_PUMP     = 8'h7d;

  localparam int          POL_BIT           = 7;
  localparam int          CUR_LSB           = 4;
  localparam int          MODE_LSB          = 2;
  localparam int          PD_LSB            = 0;

  // Pump current in units of 0.6 mA is code plus one
  localparam logic [3:0]  CUR_UNIT_OFFSET   = 4'h1;

  typedef enum logic [1:0] {
    PCC_PUMP_HIGHZ  = 2'h0,
    PCC_PUMP_SOURCE = 2'h1,
    PCC_PUMP_SINK   = 2'h2,
    PCC_PUMP_NORMAL = 2'h3
  } pcc_pump_mode_t;

  typedef enum logic [1:0] {
    PCC_PD_RUN      = 2'h0,
    PCC_PD_ASYNC    = 2'h1,
    PCC_PD_UNUSED   = 2'h2,
    PCC_PD_SYNC     = 2'h3
  } pcc_power_down_t;

  // Register write and read request from the serial port
  typedef struct packed {
    logic              wr_en;
    logic              rd_en;
    logic [9:0]        addr;
    logic [7:0]        wdata;
  } pcc_req_t;

  // Decoded loop controls toward the analog loop
  typedef struct packed {
    logic              phase_detector_polarity;
    logic [2:0]        pump_current_select;
    pcc_pump_mode_t    pump_operating_mode;
    pcc_power_down_t   loop_power_down;
  } pcc_loop_ctrl_t;

endpackage : pcc_pkg

// ---- verilog/pcc_loop_regs.sv ----
// Purpose: Settings version tag and loop/pump control byte
// Assumes: Serial port decoder presents one-cycle write/read strobes
// Notes:   Soft reset reloads on-chip defaults like srst
`timescale 1ns/1ps
`default_nettype none

module pcc_loop_regs (
  // Clock and resets
  input  wire logic                      clk_sys,
  input  wire logic                      srst,
  input  wire logic                      soft_rst,
  // Register access
  input  wire pcc_pkg::pcc_req_t         req,
  output var  logic [7:0]                rdata,
  output var  logic                      rvalid,
  output var  logic                      hit,
  // Loop controls
  output var  pcc_pkg::pcc_loop_ctrl_t   loop_ctrl,
  output var  logic [3:0]                pump_current_units,
  output var  logic                      loop_running,
  // Version tag
  output var  logic [15:0]               settings_version_tag
);

  logic [7:0]  tag_low;
  logic [7:0]  tag_high;
  logic [7:0]  loop_pump;
  logic [7:0]  next_tag_low;
  logic [7:0]  next_tag_high;
  logic [7:0]  next_loop_pump;
  logic [7:0]  next_rdata;
  logic        next_rvalid;
  logic        next_hit;
  logic        sel_low;
  logic        sel_high;
  logic        sel_pump;

  assign sel_low  = req.addr == pcc_pkg::ADDR_TAG_LOW;
  assign sel_high = req.addr == pcc_pkg::ADDR_TAG_HIGH;
  assign sel_pump = req.addr == pcc_pkg::ADDR_LOOP_PUMP;

  // Register state
  always_comb begin
    next_tag_low   = tag_low;
    next_tag_high  = tag_high;
    next_loop_pump = loop_pump;
    if (srst || soft_rst) begin
      next_tag_low   = pcc_pkg::RST_TAG_LOW;
      next_tag_high  = pcc_pkg::RST_TAG_HIGH;
      next_loop_pump = pcc_pkg::RST_LOOP_PUMP;
    end else if (req.wr_en) begin
      if (sel_low) begin
        next_tag_low = req.wdata;
      end
      if (sel_high) begin
        next_tag_high = req.wdata;
      end
      // All codes stored, incl. unused 10 and negative polarity; host owns them
      if (sel_pump) begin
        next_loop_pump = req.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    tag_low   <= next_tag_low;
    tag_high  <= next_tag_high;
    loop_pump <= next_loop_pump;
  end

  // Readback, one cycle after the strobe; unmapped reads return zero
  always_comb begin
    next_rdata  = 8'h00;
    next_rvalid = 1'b0;
    next_hit    = 1'b0;
    if (!srst && req.rd_en) begin
      next_rvalid = 1'b1;
      next_hit    = sel_low || sel_high || sel_pump;
      if (sel_low) begin
        next_rdata = tag_low;
      end else if (sel_high) begin
        next_rdata = tag_high;
      end else if (sel_pump) begin
        next_rdata = loop_pump;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    rdata  <= next_rdata;
    rvalid <= next_rvalid;
    hit    <= next_hit;
  end

  // Decoded controls, registered so outputs come from flops
  pcc_pkg::pcc_loop_ctrl_t next_loop_ctrl;
  logic [3:0]              next_units;
  logic                    next_running;

  always_comb begin
    // Only loop_pump feeds these; the tag never reaches the loop
    next_loop_ctrl.phase_detector_polarity = next_loop_pump[pcc_pkg::POL_BIT];
    next_loop_ctrl.pump_current_select =
      next_loop_pump[pcc_pkg::CUR_LSB +: 3];
    next_loop_ctrl.pump_operating_mode =
      pcc_pkg::pcc_pump_mode_t'(next_loop_pump[pcc_pkg::MODE_LSB +: 2]);
    next_loop_ctrl.loop_power_down =
      pcc_pkg::pcc_power_down_t'(next_loop_pump[pcc_pkg::PD_LSB +: 2]);
    next_units = {1'b0, next_loop_pump[pcc_pkg::CUR_LSB +: 3]}
      + pcc_pkg::CUR_UNIT_OFFSET;
    next_running = next_loop_pump[pcc_pkg::PD_LSB +: 2] == 2'h0;
  end

  always_ff @(posedge clk_sys) begin
    loop_ctrl            <= next_loop_ctrl;
    pump_current_units   <= next_units;
    loop_running         <= next_running;
    settings_version_tag <= {next_tag_high, next_tag_low};
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Reset defaults; the reset itself must not disable this one
  reset_default_a: assert property (
    disable iff (1'b0)
    srst |=> loop_ctrl == pcc_pkg::RST_LOOP_PUMP && !rvalid && !hit
      && settings_version_tag == {pcc_pkg::RST_TAG_HIGH, pcc_pkg::RST_TAG_LOW})
    else $error("reset default wrong");

  tag_low_wr_a: assert property (
    req.wr_en && sel_low && !soft_rst
    |=> settings_version_tag[7:0] == $past(req.wdata))
    else $error("tag low byte not stored");

  tag_high_wr_a: assert property (
    req.wr_en && sel_high && !soft_rst
    |=> settings_version_tag[15:8] == $past(req.wdata))
    else $error("tag high byte not stored");

  // Tag and unmapped writes must leave the loop alone
  tag_isolated_a: assert property (
    req.wr_en && (sel_low || sel_high) && !soft_rst
    |=> $stable(loop_ctrl) && $stable(pump_current_units) && $stable(loop_running))
    else $error("tag write moved loop controls");

  unmapped_wr_a: assert property (
    req.wr_en && !(sel_low || sel_high || sel_pump) && !soft_rst
    |=> $stable(loop_ctrl) && $stable(settings_version_tag))
    else $error("unmapped write changed state");

  polarity_bit_a: assert property (
    req.wr_en && sel_pump && !soft_rst
    |=> loop_ctrl.phase_detector_polarity == $past(req.wdata[7]))
    else $error("polarity not from bit 7");

  current_units_a: assert property (
    req.wr_en && sel_pump && !soft_rst
    |=> loop_ctrl.pump_current_select == $past(req.wdata[6:4])
      && pump_current_units == {1'b0, $past(req.wdata[6:4])} + pcc_pkg::CUR_UNIT_OFFSET)
    else $error("pump current units wrong");

  units_range_a: assert property (
    pump_current_units inside {[4'h1:4'h8]})
    else $error("pump current units out of range");

  pump_mode_a: assert property (
    req.wr_en && sel_pump && !soft_rst
    |=> loop_ctrl.pump_operating_mode == $past(req.wdata[3:2]))
    else $error("pump mode not from bits 3:2");

  power_down_a: assert property (
    req.wr_en && sel_pump && !soft_rst
    |=> loop_ctrl.loop_power_down == $past(req.wdata[1:0])
      && loop_running == ($past(req.wdata[1:0]) == 2'h0))
    else $error("loop running flag wrong");

  run_flag_a: assert property (
    loop_running == (loop_ctrl.loop_power_down == pcc_pkg::PCC_PD_RUN))
    else $error("loop running flag disagrees with field");

  // A write in the same cycle as soft reset is lost on purpose
  soft_default_a: assert property (
    soft_rst
    |=> loop_ctrl == pcc_pkg::RST_LOOP_PUMP
      && settings_version_tag == {pcc_pkg::RST_TAG_HIGH, pcc_pkg::RST_TAG_LOW})
    else $error("soft reset default wrong");

  // Read answers stand for exactly the cycle after the strobe
  read_back_a: assert property (
    req.rd_en && sel_pump && !req.wr_en && !soft_rst
    |=> rvalid && hit && rdata == $past(loop_pump))
    else $error("pump byte readback wrong");

  read_tag_a: assert property (
    req.rd_en && (sel_low || sel_high)
    |=> rvalid && hit && rdata == ($past(sel_low) ? $past(tag_low) : $past(tag_high)))
    else $error("tag byte readback wrong");

  read_miss_a: assert property (
    req.rd_en && !(sel_low || sel_high || sel_pump)
    |=> rvalid && !hit && rdata == 8'h00)
    else $error("unmapped read not empty");

  read_pulse_a: assert property (
    (rvalid || hit) |-> rvalid && $past(req.rd_en))
    else $error("read answer without strobe");

  // Main scenarios; the bench reaches all but tag_cov, as it never drives two writes on back-to-back cycles
  run_cov: cover property (req.wr_en && sel_pump && req.wdata[1:0] == 2'h0 ##1 loop_running);
  tag_cov: cover property (req.wr_en && sel_high ##1 req.wr_en && sel_low);
  miss_cov: cover property (req.rd_en && !(sel_low || sel_high || sel_pump));
  soft_cov: cover property (soft_rst && req.wr_en ##1 loop_ctrl == pcc_pkg::RST_LOOP_PUMP);
  pol_cov: cover property (req.wr_en && sel_pump && req.wdata[7]
    ##1 loop_ctrl.phase_detector_polarity);

endmodule : pcc_loop_regs

`default_nettype wire

// ---- bench/pcc_host.sv ----
// Purpose: Host model driving register requests
// Assumes: External oscillator, so negative polarity is allowed
// Notes:   Released address and data lines show the inverse value
`timescale 1ns/1ps
`default_nettype none
module pcc_host (
  // Clock
  input  wire logic              clk_sys,
  // Requests and answers
  output var  pcc_pkg::pcc_req_t req,
  input  wire logic [7:0]        rdata,
  input  wire logic              rvalid,
  input  wire logic              hit
);
  initial req = '0;
  // Power-down code 00 comes from the caller when the loop must run
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic v, output logic h);
    @(posedge clk_sys);
    #1;
    req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
    @(posedge clk_sys);
    #1;
    q = rdata;
    v = rvalid;
    h = hit;
    req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : pcc_host
`default_nettype wire

// ---- bench/tb_pll_charge_pump_config.sv ----
// Purpose: Self-checking bench for the loop and pump control slice
// Assumes: One-cycle read answer, writes visible one edge later
// Notes:   Seed 98, random tag bytes and unmapped addresses
`timescale 1ns/1ps
`default_nettype none
module tb_pll_charge_pump_config;
  logic clk_sys = 0, srst = 1, soft_rst = 0, rvalid, hit, loop_running, v, h;
  logic [7:0] rdata, q, d, ec;
  logic [9:0] a;
  logic [3:0] units;
  logic [15:0] tag, et;
  pcc_pkg::pcc_req_t req;
  pcc_pkg::pcc_loop_ctrl_t loop_ctrl;
  int fail_count = 0, checks = 0, cyc = 0;
  always #10 clk_sys = ~clk_sys;
  pcc_loop_regs i_pcc_loop_regs (.clk_sys(clk_sys), .srst(srst), .soft_rst(soft_rst),
    .req(req), .rdata(rdata), .rvalid(rvalid), .hit(hit), .loop_ctrl(loop_ctrl),
    .pump_current_units(units), .loop_running(loop_running), .settings_version_tag(tag));
  pcc_host i_pcc_host (.clk_sys(clk_sys), .req(req), .rdata(rdata), .rvalid(rvalid), .hit(hit));
  function automatic logic mapped(input logic [9:0] x);
    return x == 10'h005 || x == 10'h006 || x == 10'h010;
  endfunction : mapped
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic outs();
    chk(loop_ctrl === ec && units === {1'b0, ec[6:4]} + 4'h1 && tag === et
        && loop_running === (ec[1:0] == 2'h0), "decoded outputs");
  endtask : outs
  task automatic rd(input logic [9:0] x, input logic [7:0] e);
    i_pcc_host.xfer(1'b0, x, 8'h00, q, v, h);
    chk(v === 1'b1 && h === mapped(x) && q === e, "readback");
  endtask : rd
  task automatic wr(input logic [9:0] x, input logic [7:0] e);
    i_pcc_host.xfer(1'b1, x, e, q, v, h);
  endtask : wr
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    d = 8'($urandom(98));
    repeat (6) @(posedge clk_sys);
    #1 srst = 0;
    ec = 8'h7d;
    et = 16'h0000;
    outs();
    rd(10'h005, 8'h00);
    rd(10'h006, 8'h00);
    rd(10'h010, 8'h7d);
    $display("test reset done");
    for (int i = 0; i < 256; i++) begin
      ec = 8'(i);
      wr(10'h010, ec);
      outs();
      rd(10'h010, ec);
    end
    $display("test loop byte done");
    repeat (20) begin
      d = 8'($urandom);
      a = ($urandom % 2) ? 10'h006 : 10'h005;
      if (a == 10'h005) et[7:0] = d;
      else et[15:8] = d;
      wr(a, d);
      outs();
      rd(a, d);
    end
    $display("test tag done");
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? 10'h004 : (i == 1) ? 10'h011 : 10'($urandom);
      if (!mapped(a)) begin
        wr(a, 8'($urandom));
        outs();
        rd(a, 8'h00);
      end
    end
    $display("test unmapped done");
    @(posedge clk_sys);
    #1 soft_rst = 1;
    wr(10'h010, 8'h00);
    soft_rst = 0;
    ec = 8'h7d;
    et = 16'h0000;
    outs();
    $display("test soft reset done");
    wr(10'h006, 8'($urandom));
    wr(10'h010, 8'h00);
    srst = 1;
    @(posedge clk_sys);
    #1 srst = 0;
    outs();
    rd(10'h006, 8'h00);
    rd(10'h010, 8'h7d);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : tb_pll_charge_pump_config
`default_nettype wire
